// ===== bench/network_link_health_monitor_test.sv
`timescale 1ns/1ps
module network_link_health_monitor_test;
	import nlhm_pkg::*;
	logic clk, rst_n, psel, pen, pwr, prdy, slv, serr, online, fail, idone, cval, frz, derr, loff, irq;
	logic [7:0] padr;
	logic [31:0] pwd, prd, q;
	logic [9:0] scan;
	logic [63:0] peer;
	nlhm_words_t cw, sw, sto;
	nlhm_faults_t flt, flt2;
	int failures, checks_done;
	localparam logic [31:0] TMO = 32'h0000_0028;
	logic [7:0] ra [5] = '{NLHM_OFS_CTRL, NLHM_OFS_IRQ_MASK, NLHM_OFS_HB_TIMEOUT,
		NLHM_OFS_SLOT_USAGE, NLHM_OFS_PEER_SEL};
	logic [31:0] rv [5] = '{NLHM_CTRL_RST, 32'h0000_0000, TMO, NLHM_SLOT_USAGE_RST,
		NLHM_PEER_SEL_RST};
	nlhm_monitor #(.HB_TIMEOUT_CYC(TMO)) nlhm_monitor_i (.I_MCLK(clk), .I_NRST(rst_n),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
		.O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(slv), .I_LINK_ONLINE(online),
		.I_INTERNAL_FAIL(fail), .I_POWER_INIT_DONE(idone), .I_SCAN_HEALTHY(scan),
		.I_PEER_ONLINE(peer), .I_CMD_VALID(cval), .I_CMD_WORDS(cw), .I_STAT_WORDS(sw),
		.O_STAT_WORDS(sto), .O_FAULTS(flt), .O_LINK_OFFLINE(loff), .O_IRQ(irq));
	nlhm_monitor #(.PEER_SUPPORT(1'b0), .HB_TIMEOUT_CYC(TMO)) nlhm_monitor_nopeer_i (
		.I_MCLK(clk), .I_NRST(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(), .O_PREADY(), .O_PSLVERR(),
		.I_LINK_ONLINE(online), .I_INTERNAL_FAIL(fail), .I_POWER_INIT_DONE(idone),
		.I_SCAN_HEALTHY(scan), .I_PEER_ONLINE(peer), .I_CMD_VALID(cval), .I_CMD_WORDS(cw),
		.I_STAT_WORDS(sw), .O_STAT_WORDS(), .O_FAULTS(flt2), .O_LINK_OFFLINE(), .O_IRQ());
	nlhm_master_model #(.TOG(8), .LIM(12)) nlhm_master_model_i (.clk(clk), .rst_n(rst_n),
		.freeze(frz), .echo(sto), .cmd_valid(cval), .cmd_words(cw), .drive_err(derr));
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no cycle count is assumed here; only the watchdog ends a stuck access
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		q = prd;
		serr = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(s, e, q & m);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// moving pass-through data so a stuck status register shows up
	always @(posedge clk) sw <= rst_n ? sw + 48'h0001_0003_0005 : '0;
	initial begin
		pause(20000);
		failures++;
		final_report();
	end
	initial begin
		{rst_n, psel, pen, pwr, online, fail, frz} = 7'h00;
		padr = 8'h00;
		pwd = 32'h0000_0000;
		idone = 1'b1;
		scan = 10'h3FF;
		peer = '1;
		pause(16);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rdc("reset value", ra[i], 32'hFFFF_FFFF, rv[i]);
		end
		rdc("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, 32'(serr));
		apb(1'b1, NLHM_OFS_CTRL, 32'hFFFF_FFFF);
		rdc("ctrl", NLHM_OFS_CTRL, 32'hFFFF_FFFF, NLHM_CTRL_MASK);
		rdc("init status", NLHM_OFS_STATUS, 32'h0000_000F, 32'h0000_0006);
		online <= 1'b1;
		scan <= 10'h3F7;
		pause(10);
		chk("unused slot", 32'h0000_0000, 32'(flt));
		apb(1'b1, NLHM_OFS_SLOT_USAGE, 32'h0000_0040);
		rdc("stale slot", NLHM_OFS_STATUS, 32'h0000_100F, 32'h0000_1004);
		scan <= 10'h3FF;
		peer[5] <= 1'b0;
		apb(1'b1, NLHM_OFS_PEER_SEL, 32'h00C5_0000);
		pause(10);
		chk("peer", 32'h0000_0008, 32'(flt));
		chk("no peer variant", 32'h0000_0000, 32'(flt2.peer_link_fault));
		apb(1'b1, NLHM_OFS_PEER_SEL, 32'h0000_0000);
		pause(4);
		chk("peer zero", 32'h0000_0000, 32'(flt));
		chk("echo", 32'h0000_0000, 32'(derr));
		frz <= 1'b1;
		pause(70);
		chk("stuck pulse", 32'h0000_0004, 32'(flt));
		frz <= 1'b0;
		pause(30);
		chk("pulse back", 32'h0000_0000, 32'(flt));
		apb(1'b1, NLHM_OFS_IRQ_STAT, 32'h0000_000F);
		fail <= 1'b1;
		pause(10);
		chk("own fault", 32'h0000_0001, 32'(flt));
		chk("own offline", 32'h0000_0001, 32'(loff));
		chk("irq masked", 32'h0000_0000, 32'(irq));
		apb(1'b1, NLHM_OFS_IRQ_MASK, 32'h0000_0001);
		pause(2);
		chk("irq on", 32'h0000_0001, 32'(irq));
		fail <= 1'b0;
		pause(10);
		chk("irq sticky", 32'h0000_0001, 32'(irq));
		apb(1'b1, NLHM_OFS_IRQ_STAT, 32'h0000_0001);
		pause(2);
		chk("irq cleared", 32'h0000_0000, 32'(irq));
		final_report();
	end
endmodule

// ===== bench/nlhm_master_model.sv
`timescale 1ns/1ps
module nlhm_master_model #(
	parameter int TOG = 8,
	parameter int LIM = 12
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // reset, active low
	input wire logic freeze, // stop toggling the pulse
	input wire nlhm_pkg::nlhm_words_t echo, // status words from the drive
	output logic cmd_valid, // command word strobe
	output nlhm_pkg::nlhm_words_t cmd_words, // command words
	output logic drive_err // echo lagged too long
);
	import nlhm_pkg::*;
	int cnt;
	int lag;
	logic hb;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= 0;
			hb <= 1'b0;
			lag <= 0;
			drive_err <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_words <= '0;
		end else begin
			cnt <= (cnt == TOG - 1) ? 0 : cnt + 1;
			if (cnt == TOG - 1 && !freeze) begin
				hb <= ~hb;
			end
			cmd_valid <= (cnt[1:0] == 2'h0);
			// between strobes the pulse bit is inverted, so a reader ignoring valid sees junk
			cmd_words <= {3{cnt[12:0], hb ^ (cnt[1:0] != 2'h0), 2'h1}};
			lag <= (echo.word1[0] != hb) ? lag + 1 : 0;
			drive_err <= (lag > LIM);
		end
	end
endmodule

// ===== bench/nlhm_properties.sv
`timescale 1ns/1ps
module nlhm_properties #(
	parameter logic PEER_SUPPORT = 1'b1
) (
	input wire logic I_MCLK,
	input wire logic I_NRST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_LINK_ONLINE,
	input wire logic I_INTERNAL_FAIL,
	input wire logic I_CMD_VALID,
	input wire nlhm_pkg::nlhm_words_t I_CMD_WORDS,
	input wire nlhm_pkg::nlhm_words_t I_STAT_WORDS,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire nlhm_pkg::nlhm_words_t O_STAT_WORDS,
	input wire nlhm_pkg::nlhm_faults_t O_FAULTS,
	input wire logic O_LINK_OFFLINE
);
	import nlhm_pkg::*;
	default clocking @(posedge I_MCLK);
	endclocking
	default disable iff (!I_NRST);
	a_ready_zero_wait: assert property (O_PREADY == (I_PSEL && I_PENABLE))
		else $error("pready out of step with access");
	a_err_in_access: assert property (O_PSLVERR |-> O_PREADY)
		else $error("pslverr outside access");
	a_rdata_holds: assert property (I_PSEL && I_PENABLE |=> $stable(O_PRDATA))
		else $error("read data moved after access");
	a_echo_value: assert property (I_CMD_VALID |-> ##2 O_STAT_WORDS.word2[0] ==
		$past(I_CMD_WORDS.word2[2], 2)) else $error("echo differs from received pulse");
	a_echo_no_toggle: assert property (!I_CMD_VALID |-> ##2 $stable(O_STAT_WORDS.word4[0]))
		else $error("echo changed without new command");
	a_status_copy: assert property ($past(I_NRST) |->
		O_STAT_WORDS.word1[15:1] == $past(I_STAT_WORDS.word1[15:1]))
		else $error("status word not passed through");
	a_offline_fault: assert property (!I_LINK_ONLINE [*7] |=>
		O_FAULTS.master_link_fault && O_LINK_OFFLINE) else $error("offline link not flagged");
	a_own_raise: assert property ((I_INTERNAL_FAIL && I_LINK_ONLINE) [*8] |=>
		O_FAULTS.own_station_fault) else $error("own fault not raised");
	a_own_clear: assert property (!I_INTERNAL_FAIL [*8] |=> !O_FAULTS.own_station_fault)
		else $error("own fault without failure");
	a_peer_gated: assert property (!PEER_SUPPORT |-> !O_FAULTS.peer_link_fault)
		else $error("peer fault on variant without peers");
	c_link_fault: cover property (O_FAULTS.master_link_fault && I_LINK_ONLINE);
	c_own_fault: cover property (O_FAULTS.own_station_fault);
	c_refused: cover property (O_PSLVERR);
endmodule

bind nlhm_monitor nlhm_properties #(.PEER_SUPPORT(PEER_SUPPORT)) nlhm_properties_i (.I_MCLK,
	.I_NRST, .I_PSEL, .I_PENABLE, .I_LINK_ONLINE, .I_INTERNAL_FAIL, .I_CMD_VALID, .I_CMD_WORDS,
	.I_STAT_WORDS, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_STAT_WORDS, .O_FAULTS, .O_LINK_OFFLINE);

// ===== rtl/nlhm_monitor.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// R01 - internal failure while online raises own fault
// R02 - no online after init raises init fault
// R03 - offline master link raises link fault
// R04 - any selected peer offline raises peer fault
// R05 - unused slots and zero selects are ignored
// R06 - peer fault only on variants supporting it
// R07 - received heartbeat is command word bit 2
// R08 - returned heartbeat is status word bit 0
// R09 - heartbeat echoed as received, never self-toggled
// R10 - master toggles heartbeat periodically
// R11 - stuck heartbeat beyond timeout raises link fault
// R12 - master flags drive when echo lags
// R13 - heartbeat timeout is a configurable cycle count
module nlhm_monitor #(
	parameter logic PEER_SUPPORT = 1'b1,
	parameter logic [31:0] HB_TIMEOUT_CYC = 32'(nlhm_pkg::NLHM_HB_TIMEOUT_CYC),
	parameter int STA_W = nlhm_pkg::NLHM_STA_W
) (
	input wire logic I_MCLK, // system clock
	input wire logic I_NRST, // synchronous reset, active low
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb access phase
	input wire logic I_PWRITE, // apb direction
	input wire logic [nlhm_pkg::NLHM_ADDR_W-1:0] I_PADDR, // apb byte address
	input wire logic [31:0] I_PWDATA, // apb write data
	output logic [31:0] O_PRDATA, // apb read data
	output logic O_PREADY, // apb ready
	output logic O_PSLVERR, // apb error on unmapped address
	input wire logic I_LINK_ONLINE, // pin: link in online mode
	input wire logic I_INTERNAL_FAIL, // pin: board watchdog or cpu failure
	input wire logic I_POWER_INIT_DONE, // pin: power initialization complete
	input wire logic [nlhm_pkg::NLHM_SLOTS-1:0] I_SCAN_HEALTHY, // pin: slot data fresh
	input wire logic [2**STA_W-1:0] I_PEER_ONLINE, // pin: peer station online map
	input wire logic I_CMD_VALID, // new serial command words
	input wire nlhm_pkg::nlhm_words_t I_CMD_WORDS, // serial command words 1, 2, 4
	input wire nlhm_pkg::nlhm_words_t I_STAT_WORDS, // status words before echo
	output nlhm_pkg::nlhm_words_t O_STAT_WORDS, // status words with echo inserted
	output nlhm_pkg::nlhm_faults_t O_FAULTS, // live fault flags
	output logic O_LINK_OFFLINE, // link reported offline
	output logic O_IRQ // interrupt, level
);
	import nlhm_pkg::*;

	localparam int NSTA = 2**STA_W;

	// three-stage synchronisers; the filtered value moves only where stages two and three agree
	localparam int SYNC_W = 3 + NLHM_SLOTS + NSTA;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	logic [SYNC_W-1:0] filt_reg;
	logic [SYNC_W-1:0] filt_next;

	function automatic logic [SYNC_W-1:0] agree(input logic [SYNC_W-1:0] s2,
		input logic [SYNC_W-1:0] s3, input logic [SYNC_W-1:0] held);
		logic [SYNC_W-1:0] diff;
		diff = s2 ^ s3;
		agree = (s3 & ~diff) | (held & diff);
	endfunction

	assign filt_next = agree(sync2_reg, sync3_reg, filt_reg);

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			filt_reg <= '0;
		end else begin
			sync1_reg <= {I_PEER_ONLINE, I_SCAN_HEALTHY, I_POWER_INIT_DONE, I_INTERNAL_FAIL,
				I_LINK_ONLINE};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg <= filt_next;
		end
	end

	logic online;
	logic int_fail;
	logic init_done;
	logic [NLHM_SLOTS-1:0] scan_healthy;
	logic [NSTA-1:0] peer_online;
	assign online = filt_reg[0];
	assign int_fail = filt_reg[1];
	assign init_done = filt_reg[2];
	assign scan_healthy = filt_reg[3 +: NLHM_SLOTS];
	assign peer_online = filt_reg[3 + NLHM_SLOTS +: NSTA];

	// software registers
	logic [31:0] ctrl_reg;
	logic [31:0] hb_timeout_reg;
	logic [31:0] slot_usage_reg;
	logic [31:0] peer_sel_reg;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_mask_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	logic hb_en;
	logic [1:0] hb_src;
	assign hb_en = ctrl_reg[NLHM_CTRL_HB_EN];
	assign hb_src = ctrl_reg[NLHM_CTRL_SRC_LSB +: 2];

	// own station fault: only a failure seen while the link was online counts
	logic own_fault_reg;
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			own_fault_reg <= 1'b0;
		end else if (int_fail && online) begin
			own_fault_reg <= 1'b1; // [R01]
		end else if (!int_fail) begin
			own_fault_reg <= 1'b0;
		end
	end

	// init fault: init done but online never reached since reset
	logic been_online_reg;
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			been_online_reg <= 1'b0;
		end else if (online) begin
			been_online_reg <= 1'b1;
		end
	end

	logic init_fault;
	assign init_fault = init_done && !been_online_reg && !online; // [R02]

	// heartbeat receive and echo
	logic hb_rx_reg;
	logic hb_sel;
	always_comb begin
		case (hb_src)
			NLHM_SRC_WORD2: hb_sel = I_CMD_WORDS.word2[NLHM_HB_RX_BIT]; // [R07]
			NLHM_SRC_WORD4: hb_sel = I_CMD_WORDS.word4[NLHM_HB_RX_BIT]; // [R07]
			default: hb_sel = I_CMD_WORDS.word1[NLHM_HB_RX_BIT]; // [R07]
		endcase
	end

	logic hb_change;
	assign hb_change = I_CMD_VALID && (hb_sel != hb_rx_reg);

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			hb_rx_reg <= 1'b0;
		end else if (I_CMD_VALID) begin
			hb_rx_reg <= hb_sel;
		end
	end

	// echo goes straight back; the drive never toggles on its own, the master does that
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_STAT_WORDS <= '0;
		end else begin
			O_STAT_WORDS <= I_STAT_WORDS;
			O_STAT_WORDS.word1[NLHM_HB_TX_BIT] <= hb_rx_reg; // [R08] [R09]
			O_STAT_WORDS.word2[NLHM_HB_TX_BIT] <= hb_rx_reg; // [R08] [R09]
			O_STAT_WORDS.word4[NLHM_HB_TX_BIT] <= hb_rx_reg; // [R08] [R09]
		end
	end

	// stuck heartbeat timer; saturates so a long stall cannot wrap back to healthy
	logic [31:0] hb_cnt_reg;
	logic hb_timeout;
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			hb_cnt_reg <= '0;
		end else if (!hb_en || !online || hb_change) begin
			hb_cnt_reg <= '0;
		end else if (hb_cnt_reg < hb_timeout_reg) begin
			hb_cnt_reg <= hb_cnt_reg + 32'h0000_0001; // [R13]
		end
	end
	// the timeout must exceed the master toggle interval plus the round trip
	assign hb_timeout = hb_en && online && (hb_cnt_reg >= hb_timeout_reg); // [R11] [R13]

	// stale scan data on a used slot
	function automatic logic [NLHM_SLOTS-1:0] stale_slots(input logic [31:0] usage,
		input logic [NLHM_SLOTS-1:0] healthy);
		logic [NLHM_SLOTS-1:0] res;
		res = '0;
		for (int i = 0; i < NLHM_SLOTS; i++) begin
			res[i] = (usage[i*NLHM_USAGE_W +: NLHM_USAGE_W] != NLHM_UNUSED_DESIGNATION)
				&& !healthy[i]; // [R05]
		end
		return res;
	endfunction

	logic [NLHM_SLOTS-1:0] stale;
	assign stale = stale_slots(slot_usage_reg, scan_healthy);

	logic master_fault;
	assign master_fault = !online || (|stale) || hb_timeout; // [R03] [R11]

	// peer stations; select zero means nothing assigned
	function automatic logic peer_down(input logic [NSTA-1:0] map, input logic [31:0] sel);
		logic down;
		logic [STA_W-1:0] sta;
		down = 1'b0;
		for (int p = 0; p < NLHM_PEERS; p++) begin
			sta = sel[p*NLHM_PEER_FIELD_W +: STA_W];
			if (sta != '0 && !map[sta]) begin // [R05]
				down = 1'b1; // [R04]
			end
		end
		return down;
	endfunction

	logic peer_fault;
	assign peer_fault = PEER_SUPPORT && peer_down(peer_online, peer_sel_reg); // [R06]

	nlhm_faults_t faults;
	always_comb begin
		faults.own_station_fault = own_fault_reg;
		faults.init_fault = init_fault;
		faults.master_link_fault = master_fault;
		faults.peer_link_fault = peer_fault;
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_FAULTS <= '0;
			O_LINK_OFFLINE <= 1'b1;
		end else begin
			O_FAULTS <= faults;
			O_LINK_OFFLINE <= !online || own_fault_reg; // [R01]
		end
	end

	// apb slave: zero wait states, read data captured in the setup cycle
	logic setup;
	logic wr_acc;
	assign setup = I_PSEL && !I_PENABLE;
	assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
	assign O_PREADY = I_PSEL && I_PENABLE;
	assign O_PRDATA = prdata_reg;
	assign O_PSLVERR = O_PREADY && pslverr_reg;

	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[NLHM_ST_FAULT_LSB +: 4] = faults;
		status_word[NLHM_ST_ONLINE] = online;
		status_word[NLHM_ST_HB_RX] = hb_rx_reg;
		status_word[NLHM_ST_OFFLINE] = !online || own_fault_reg;
		status_word[NLHM_ST_BEEN_ON] = been_online_reg;
		status_word[NLHM_ST_HB_TMO] = hb_timeout;
		status_word[NLHM_ST_SLOT_LSB +: NLHM_SLOTS] = stale;
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= 1'b0;
			if (I_PADDR == NLHM_OFS_CTRL) begin
				prdata_reg <= ctrl_reg;
			end else if (I_PADDR == NLHM_OFS_STATUS) begin
				prdata_reg <= status_word;
			end else if (I_PADDR == NLHM_OFS_IRQ_STAT) begin
				prdata_reg <= {28'h000_0000, irq_stat_reg};
			end else if (I_PADDR == NLHM_OFS_IRQ_MASK) begin
				prdata_reg <= {28'h000_0000, irq_mask_reg};
			end else if (I_PADDR == NLHM_OFS_HB_TIMEOUT) begin
				prdata_reg <= hb_timeout_reg;
			end else if (I_PADDR == NLHM_OFS_SLOT_USAGE) begin
				prdata_reg <= slot_usage_reg;
			end else if (I_PADDR == NLHM_OFS_PEER_SEL) begin
				prdata_reg <= peer_sel_reg;
			end else begin
				prdata_reg <= '0;
				pslverr_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			ctrl_reg <= NLHM_CTRL_RST;
			hb_timeout_reg <= HB_TIMEOUT_CYC;
			slot_usage_reg <= NLHM_SLOT_USAGE_RST;
			peer_sel_reg <= NLHM_PEER_SEL_RST;
			irq_mask_reg <= '0;
		end else if (wr_acc) begin
			if (I_PADDR == NLHM_OFS_CTRL) begin
				ctrl_reg <= I_PWDATA & NLHM_CTRL_MASK;
			end else if (I_PADDR == NLHM_OFS_IRQ_MASK) begin
				irq_mask_reg <= I_PWDATA[3:0];
			end else if (I_PADDR == NLHM_OFS_HB_TIMEOUT) begin
				hb_timeout_reg <= I_PWDATA; // [R13]
			end else if (I_PADDR == NLHM_OFS_SLOT_USAGE) begin
				slot_usage_reg <= I_PWDATA;
			end else if (I_PADDR == NLHM_OFS_PEER_SEL) begin
				peer_sel_reg <= I_PWDATA;
			end
		end
	end

	// sticky fault bits; a fault still present re-sets the bit even as it is cleared
	logic [3:0] irq_clr;
	assign irq_clr = (wr_acc && I_PADDR == NLHM_OFS_IRQ_STAT) ? I_PWDATA[3:0] : 4'h0;

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | faults;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule

// ===== rtl/nlhm_pkg.sv
package nlhm_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] NLHM_OFS_CTRL = 8'h00;
	localparam logic [7:0] NLHM_OFS_STATUS = 8'h04;
	localparam logic [7:0] NLHM_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] NLHM_OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] NLHM_OFS_HB_TIMEOUT = 8'h10;
	localparam logic [7:0] NLHM_OFS_SLOT_USAGE = 8'h14;
	localparam logic [7:0] NLHM_OFS_PEER_SEL = 8'h18;
	localparam int NLHM_ADDR_W = 8;

	// control register fields
	localparam int NLHM_CTRL_HB_EN = 0;
	localparam int NLHM_CTRL_SRC_LSB = 1;
	localparam logic [31:0] NLHM_CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] NLHM_CTRL_MASK = 32'h0000_0007;

	// status register fields
	localparam int NLHM_ST_FAULT_LSB = 0;
	localparam int NLHM_ST_ONLINE = 4;
	localparam int NLHM_ST_HB_RX = 5;
	localparam int NLHM_ST_OFFLINE = 6;
	localparam int NLHM_ST_BEEN_ON = 7;
	localparam int NLHM_ST_HB_TMO = 8;
	localparam int NLHM_ST_SLOT_LSB = 9;

	// heartbeat bit positions inside the serial words
	localparam int NLHM_HB_RX_BIT = 2;
	localparam int NLHM_HB_TX_BIT = 0;

	// heartbeat source selection
	localparam logic [1:0] NLHM_SRC_WORD1 = 2'h0;
	localparam logic [1:0] NLHM_SRC_WORD2 = 2'h1;
	localparam logic [1:0] NLHM_SRC_WORD4 = 2'h2;

	// scan slots and their usage code
	localparam int NLHM_SLOTS = 10;
	localparam int NLHM_USAGE_W = 2;
	localparam logic [1:0] NLHM_UNUSED_DESIGNATION = 2'h0;
	localparam logic [31:0] NLHM_SLOT_USAGE_RST = 32'h0000_0000;

	// peer station selection
	localparam int NLHM_PEERS = 4;
	localparam int NLHM_STA_W = 6;
	localparam int NLHM_PEER_FIELD_W = 8;
	localparam logic [31:0] NLHM_PEER_SEL_RST = 32'h0000_0000;

	// heartbeat timeout
	localparam longint NLHM_CLK_HZ = 50000000;
	localparam longint NLHM_HB_TIMEOUT_MS = 100;
	localparam longint NLHM_HB_TIMEOUT_CYC = (NLHM_HB_TIMEOUT_MS * NLHM_CLK_HZ) / 1000;

	typedef struct packed {
		logic peer_link_fault;
		logic master_link_fault;
		logic init_fault;
		logic own_station_fault;
	} nlhm_faults_t;

	typedef struct packed {
		logic [15:0] word4;
		logic [15:0] word2;
		logic [15:0] word1;
	} nlhm_words_t;
endpackage
